/* File: design/gpsw_pkg.sv */
// Behaviour
// - Index f6 reads bank A pin levels
// - Index f9 reads bank B pins 0,2,3,4
// - Index fa reads bank C pin levels
// - Runtime indexes 01,03,04 alias bank read-back registers; 02,05,06 show external registers
// - Bank A pins individually enabled onto irq one
// - Bank B/C pins individually enabled onto irq two
// - Control zero: sleep write starts sleep sequence
// - Control one: sleep write raises management interrupt
// - Every sleep write sets sleep-write seen flag
// - Wake control zero: only power-on fall sets wake
// - Wake control one: enabled wake events also set
// - Bit 7 zero keeps low-speed PLL off
// - Bit 7 one runs PLL for IR wake
// - Config and read-back registers reset to zero
package gpsw_pkg;

    // ****************************************************************
    // Register indexes
    // ****************************************************************
    localparam logic [7:0] GPSW_IDX_CFG = 8'hf0;
    localparam logic [7:0] GPSW_IDX_BANK_A = 8'hf6;
    localparam logic [7:0] GPSW_IDX_BANK_B = 8'hf9;
    localparam logic [7:0] GPSW_IDX_BANK_C = 8'hfa;
    // Runtime aliases in the 01-06 window
    localparam logic [7:0] GPSW_RT_BANK_A = 8'h01;
    localparam logic [7:0] GPSW_RT_WDOG = 8'h02;
    localparam logic [7:0] GPSW_RT_BANK_B = 8'h03;
    localparam logic [7:0] GPSW_RT_BANK_C = 8'h04;
    localparam logic [7:0] GPSW_RT_SPWR_EN = 8'h05;
    localparam logic [7:0] GPSW_RT_SPWR_STS = 8'h06;
    // Block-local registers
    localparam logic [7:0] GPSW_IDX_IRQ_EN_A = 8'he0;
    localparam logic [7:0] GPSW_IDX_IRQ_EN_B = 8'he1;
    localparam logic [7:0] GPSW_IDX_IRQ_EN_C = 8'he2;
    localparam logic [7:0] GPSW_IDX_SLEEP = 8'he3;
    localparam logic [7:0] GPSW_IDX_STATUS = 8'he4;
    localparam logic [7:0] GPSW_IDX_MASK = 8'he5;

    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int GPSW_CFG_SLEEP_ACT = 0;
    localparam int GPSW_CFG_WAKE_SRC = 1;
    localparam int GPSW_CFG_PLL = 7;
    localparam logic [7:0] GPSW_CFG_MASK = 8'h83;
    localparam logic [7:0] GPSW_BANK_B_MASK = 8'h1d;
    localparam int GPSW_SLP_REQ = 0;
    localparam int GPSW_SLP_TYPE_LSB = 1;
    localparam int GPSW_ST_SLEEP_SEEN = 0;
    localparam int GPSW_ST_WAKE = 1;
    localparam int GPSW_ST_SEQ = 2;
    localparam int GPSW_ST_SMI = 3;
    localparam logic [3:0] GPSW_STATUS_RST = 4'h0;
    localparam logic [7:0] GPSW_REG_RST = 8'h00;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gpsw_bus_t;

    // Externally held registers shown through the runtime window
    typedef struct packed {
        logic [7:0] wdog;
        logic [7:0] spwr_en;
        logic [7:0] spwr_sts;
    } gpsw_ext_t;

endpackage

/* File: design/gpsw_regs.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module gpsw_regs #(
    parameter int BANK_A_W = 8,
    parameter int BANK_C_W = 8
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    input wire gpsw_pkg::gpsw_bus_t BUS,
    input wire logic CONFIG_MODE,
    input wire gpsw_pkg::gpsw_ext_t EXT_REGS,
    input wire logic [BANK_A_W-1:0] BANK_A_PINS,
    input wire logic [7:0] BANK_B_PINS,
    input wire logic [BANK_C_W-1:0] BANK_C_PINS,
    input wire logic POWER_ON_REQUEST_N,
    input wire logic WAKE_EVENT,
    output logic [7:0] RDATA,
    output logic PIN_IRQ_OUT_FIRST,
    output logic PIN_IRQ_OUT_SECOND,
    output logic SLEEP_START,
    output logic [2:0] SLEEP_TYPE,
    output logic SYSTEM_MGMT_INTERRUPT,
    output logic IR_WAKE_PLL_ENABLE,
    output logic IRQ
);

    // ****************************************************************
    // State registers
    // ****************************************************************
    logic [7:0] cfg_r, cfg_nxt;            // Sleep/wake configuration
    logic [7:0] bank_a_r, bank_a_nxt;      // Bank A sampled levels
    logic [7:0] bank_b_r, bank_b_nxt;      // Bank B sampled levels
    logic [7:0] bank_c_r, bank_c_nxt;      // Bank C sampled levels
    logic [7:0] en_a_r, en_a_nxt;          // Bank A irq enables
    logic [7:0] en_b_r, en_b_nxt;          // Bank B irq enables
    logic [7:0] en_c_r, en_c_nxt;          // Bank C irq enables
    logic [2:0] slp_type_r, slp_type_nxt;  // Sleep type field
    logic [3:0] sts_r, sts_nxt;            // Sticky event status
    logic [3:0] mask_r, mask_nxt;          // Interrupt mask
    logic pon_prev_r, pon_prev_nxt;        // Previous power-on request
    logic [7:0] rdata_r, rdata_nxt;        // Read data
    logic irq1_r, irq1_nxt;                // First pin interrupt
    logic irq2_r, irq2_nxt;                // Second pin interrupt
    logic slp_start_r, slp_start_nxt;      // Sleep sequence start pulse
    logic smi_r, smi_nxt;                  // Management interrupt pulse
    logic irq_r, irq_nxt;                  // Summary interrupt

    // Padded pin vectors
    logic [7:0] pins_a, pins_c;
    logic sleep_wr, pon_fall;
    logic [3:0] events;

    // Decode of which register an access selects; config mode aware
    function automatic logic [7:0] map_idx(input logic [7:0] a, input logic cfg_mode);
        logic [7:0] r;
        r = a;
        if (!cfg_mode) begin
            case (a)
                gpsw_pkg::GPSW_RT_BANK_A: r = gpsw_pkg::GPSW_IDX_BANK_A;
                gpsw_pkg::GPSW_RT_BANK_B: r = gpsw_pkg::GPSW_IDX_BANK_B;
                gpsw_pkg::GPSW_RT_BANK_C: r = gpsw_pkg::GPSW_IDX_BANK_C;
                default: r = a;
            endcase
        end
        return r;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [7:0] idx;
        idx = map_idx(BUS.addr, CONFIG_MODE);
        pins_a = 8'h00;
        pins_a[BANK_A_W-1:0] = BANK_A_PINS;
        pins_c = 8'h00;
        pins_c[BANK_C_W-1:0] = BANK_C_PINS;
        cfg_nxt = cfg_r;
        en_a_nxt = en_a_r;
        en_b_nxt = en_b_r;
        en_c_nxt = en_c_r;
        slp_type_nxt = slp_type_r;
        mask_nxt = mask_r;
        rdata_nxt = 8'h00;
        sleep_wr = 1'b0;
        // Sample live pin levels every cycle that CE is high
        bank_a_nxt = pins_a;
        bank_b_nxt = BANK_B_PINS & gpsw_pkg::GPSW_BANK_B_MASK;
        bank_c_nxt = pins_c;
        pon_prev_nxt = POWER_ON_REQUEST_N;
        pon_fall = pon_prev_r & ~POWER_ON_REQUEST_N;
        // Writes; read-back registers have no write decode
        if (BUS.wr) begin
            case (idx)
                gpsw_pkg::GPSW_IDX_CFG: cfg_nxt = BUS.wdata & gpsw_pkg::GPSW_CFG_MASK;
                gpsw_pkg::GPSW_IDX_IRQ_EN_A: en_a_nxt = BUS.wdata;
                gpsw_pkg::GPSW_IDX_IRQ_EN_B: en_b_nxt = BUS.wdata;
                gpsw_pkg::GPSW_IDX_IRQ_EN_C: en_c_nxt = BUS.wdata;
                gpsw_pkg::GPSW_IDX_SLEEP: begin
                    slp_type_nxt = BUS.wdata[gpsw_pkg::GPSW_SLP_TYPE_LSB +: 3];
                    sleep_wr = BUS.wdata[gpsw_pkg::GPSW_SLP_REQ];
                end
                gpsw_pkg::GPSW_IDX_MASK: mask_nxt = BUS.wdata[3:0];
                default: ;
            endcase
        end
        // Sleep write action follows the control bit
        slp_start_nxt = sleep_wr & ~cfg_r[gpsw_pkg::GPSW_CFG_SLEEP_ACT];
        smi_nxt = sleep_wr & cfg_r[gpsw_pkg::GPSW_CFG_SLEEP_ACT];
        // Sticky events
        events = 4'h0;
        events[gpsw_pkg::GPSW_ST_SLEEP_SEEN] = sleep_wr;
        events[gpsw_pkg::GPSW_ST_WAKE] = pon_fall
            | (WAKE_EVENT & cfg_r[gpsw_pkg::GPSW_CFG_WAKE_SRC]);
        events[gpsw_pkg::GPSW_ST_SEQ] = slp_start_nxt;
        events[gpsw_pkg::GPSW_ST_SMI] = smi_nxt;
        sts_nxt = sts_r;
        // Read clears status; a same-cycle event still wins
        if (BUS.rd && idx == gpsw_pkg::GPSW_IDX_STATUS) begin
            sts_nxt = 4'h0;
        end
        sts_nxt = sts_nxt | events;
        // Read mux
        if (BUS.rd) begin
            case (idx)
                gpsw_pkg::GPSW_IDX_CFG: rdata_nxt = cfg_r;
                gpsw_pkg::GPSW_IDX_BANK_A: rdata_nxt = bank_a_r;
                gpsw_pkg::GPSW_IDX_BANK_B: rdata_nxt = bank_b_r;
                gpsw_pkg::GPSW_IDX_BANK_C: rdata_nxt = bank_c_r;
                gpsw_pkg::GPSW_IDX_IRQ_EN_A: rdata_nxt = en_a_r;
                gpsw_pkg::GPSW_IDX_IRQ_EN_B: rdata_nxt = en_b_r;
                gpsw_pkg::GPSW_IDX_IRQ_EN_C: rdata_nxt = en_c_r;
                gpsw_pkg::GPSW_IDX_SLEEP: rdata_nxt = {4'h0, slp_type_r, 1'b0};
                gpsw_pkg::GPSW_IDX_STATUS: rdata_nxt = {4'h0, sts_r};
                gpsw_pkg::GPSW_IDX_MASK: rdata_nxt = {4'h0, mask_r};
                default: begin
                    // Runtime aliases of externally held registers
                    if (!CONFIG_MODE && idx == gpsw_pkg::GPSW_RT_WDOG) begin
                        rdata_nxt = EXT_REGS.wdog;
                    end else if (!CONFIG_MODE && idx == gpsw_pkg::GPSW_RT_SPWR_EN) begin
                        rdata_nxt = EXT_REGS.spwr_en;
                    end else if (!CONFIG_MODE && idx == gpsw_pkg::GPSW_RT_SPWR_STS) begin
                        rdata_nxt = EXT_REGS.spwr_sts;
                    end else begin
                        rdata_nxt = 8'h00;
                    end
                end
            endcase
        end
        // Pin interrupts from enabled high levels
        irq1_nxt = |(bank_a_r & en_a_r);
        irq2_nxt = |(bank_b_r & en_b_r) | |(bank_c_r & en_c_r);
        irq_nxt = |(sts_nxt & mask_r);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_r <= gpsw_pkg::GPSW_REG_RST;
            bank_a_r <= gpsw_pkg::GPSW_REG_RST;
            bank_b_r <= gpsw_pkg::GPSW_REG_RST;
            bank_c_r <= gpsw_pkg::GPSW_REG_RST;
            en_a_r <= gpsw_pkg::GPSW_REG_RST;
            en_b_r <= gpsw_pkg::GPSW_REG_RST;
            en_c_r <= gpsw_pkg::GPSW_REG_RST;
            slp_type_r <= 3'h0;
            sts_r <= gpsw_pkg::GPSW_STATUS_RST;
            mask_r <= gpsw_pkg::GPSW_STATUS_RST;
            pon_prev_r <= 1'b1;
            rdata_r <= gpsw_pkg::GPSW_REG_RST;
            irq1_r <= 1'b0;
            irq2_r <= 1'b0;
            slp_start_r <= 1'b0;
            smi_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (CE) begin
            cfg_r <= cfg_nxt;
            bank_a_r <= bank_a_nxt;
            bank_b_r <= bank_b_nxt;
            bank_c_r <= bank_c_nxt;
            en_a_r <= en_a_nxt;
            en_b_r <= en_b_nxt;
            en_c_r <= en_c_nxt;
            slp_type_r <= slp_type_nxt;
            sts_r <= sts_nxt;
            mask_r <= mask_nxt;
            pon_prev_r <= pon_prev_nxt;
            rdata_r <= rdata_nxt;
            irq1_r <= irq1_nxt;
            irq2_r <= irq2_nxt;
            slp_start_r <= slp_start_nxt;
            smi_r <= smi_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign RDATA = rdata_r;
    assign PIN_IRQ_OUT_FIRST = irq1_r;
    assign PIN_IRQ_OUT_SECOND = irq2_r;
    assign SLEEP_START = slp_start_r;
    assign SLEEP_TYPE = slp_type_r;
    assign SYSTEM_MGMT_INTERRUPT = smi_r;
    assign IR_WAKE_PLL_ENABLE = cfg_r[gpsw_pkg::GPSW_CFG_PLL];
    assign IRQ = irq_r;

endmodule

/* File: dv/gpsw_regs_props.sv */
`timescale 1ns/1ps
module gpsw_regs_chk #(
    parameter int BANK_A_W = 8,
    parameter int BANK_C_W = 8
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    input wire gpsw_pkg::gpsw_bus_t BUS,
    input wire logic CONFIG_MODE,
    input wire logic [BANK_A_W-1:0] BANK_A_PINS,
    input wire logic [7:0] BANK_B_PINS,
    input wire logic [7:0] RDATA,
    input wire logic SLEEP_START,
    input wire logic SYSTEM_MGMT_INTERRUPT,
    input wire logic IR_WAKE_PLL_ENABLE,
    input wire logic IRQ
);
    // ****************************************************************
    // Shadow of the sleep-write action select
    // ****************************************************************
    logic act_r; // Copy of config bit 0
    logic act_nxt; // Next copy
    wire logic cfg_wr = CE && BUS.wr && BUS.addr == gpsw_pkg::GPSW_IDX_CFG; // Config write
    wire logic slp_wr = CE && BUS.wr && BUS.addr == gpsw_pkg::GPSW_IDX_SLEEP && BUS.wdata[0];
    wire logic rd_a = CE && BUS.rd && (BUS.addr == gpsw_pkg::GPSW_IDX_BANK_A
        || (BUS.addr == gpsw_pkg::GPSW_RT_BANK_A && !CONFIG_MODE)); // Bank A read
    // Follow config writes
    always_comb begin
        act_nxt = cfg_wr ? BUS.wdata[0] : act_r;
    end
    // Register the copy
    always_ff @(posedge CLOCK) begin
        act_r <= RST ? 1'b0 : act_nxt;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_sleep_start_go: assert property (slp_wr && !act_r |=> SLEEP_START)
        else $error("sleep write did not start sleep");
    a_smi_instead: assert property (slp_wr && act_r |=> SYSTEM_MGMT_INTERRUPT && !SLEEP_START)
        else $error("sleep write did not raise management interrupt");
    a_pulse_cause: assert property (SLEEP_START || SYSTEM_MGMT_INTERRUPT |-> $past(slp_wr))
        else $error("sleep pulse without a sleep write");
    a_pll_follows: assert property ($past(cfg_wr) |-> IR_WAKE_PLL_ENABLE == $past(BUS.wdata[7]))
        else $error("pll enable differs from written bit");
    a_pll_holds: assert property (!$past(cfg_wr) && !$past(RST) |-> $stable(IR_WAKE_PLL_ENABLE))
        else $error("pll enable moved without config write");
    a_bank_a_read: assert property ($past(rd_a) && $past(BANK_A_PINS) == $past(BANK_A_PINS, 2)
        |-> RDATA == 8'($past(BANK_A_PINS))) else $error("bank A read-back wrong");
    a_bank_b_read: assert property ($past(CE && BUS.rd && BUS.addr == gpsw_pkg::GPSW_IDX_BANK_B)
        && $past(BANK_B_PINS) == $past(BANK_B_PINS, 2)
        |-> RDATA == ($past(BANK_B_PINS) & 8'h1d)) else $error("bank B read-back wrong");
    a_cfg_reserved: assert property ($past(CE && BUS.rd && BUS.addr == 8'hf0) |-> RDATA[6:2] == 5'h00)
        else $error("reserved config bits not zero");
    a_reset_quiet: assert property ($past(RST) |-> !IRQ && !SLEEP_START && RDATA == 8'h00)
        else $error("outputs active after reset");
endmodule
bind gpsw_regs gpsw_regs_chk #(.BANK_A_W(BANK_A_W), .BANK_C_W(BANK_C_W)) i_chk (
    .CLOCK(CLOCK), .RST(RST), .CE(CE), .BUS(BUS), .CONFIG_MODE(CONFIG_MODE),
    .BANK_A_PINS(BANK_A_PINS), .BANK_B_PINS(BANK_B_PINS), .RDATA(RDATA), .IRQ(IRQ),
    .SLEEP_START(SLEEP_START), .SYSTEM_MGMT_INTERRUPT(SYSTEM_MGMT_INTERRUPT),
    .IR_WAKE_PLL_ENABLE(IR_WAKE_PLL_ENABLE));

/* File: dv/tb_gpsw_regs.sv */
`timescale 1ns/1ps
module tb_gpsw_regs;
    // ****************************************************************
    // Stimulus and observation
    // ****************************************************************
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    gpsw_pkg::gpsw_bus_t bus = '0; // Register bus request
    gpsw_pkg::gpsw_ext_t ext = '0; // Outside registers
    logic cfg_mode = 1'b1;
    logic ce = 1'b1; // Clock enable
    logic [7:0] pa = '0, pb = '0, pc = '0, ea, eb, ec; // Pin levels and enables
    logic pon_n = 1'b1, wake_ev = 1'b0;
    logic [7:0] rdata;
    logic irq1, irq2, slp, system_mgmt_interrupt, pll, irq;
    logic [2:0] slp_type, t;
    int fails = 0, compares = 0;
    gpsw_regs i_dut (.CLOCK(CLOCK), .RST(RST), .CE(ce), .BUS(bus), .CONFIG_MODE(cfg_mode),
        .EXT_REGS(ext), .BANK_A_PINS(pa), .BANK_B_PINS(pb), .BANK_C_PINS(pc), .RDATA(rdata),
        .POWER_ON_REQUEST_N(pon_n), .WAKE_EVENT(wake_ev), .PIN_IRQ_OUT_FIRST(irq1),
        .PIN_IRQ_OUT_SECOND(irq2), .SLEEP_START(slp), .SLEEP_TYPE(slp_type),
        .SYSTEM_MGMT_INTERRUPT(system_mgmt_interrupt), .IR_WAKE_PLL_ENABLE(pll), .IRQ(irq));
    // Free-running clock
    initial begin
        forever #25 CLOCK = ~CLOCK;
    end
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] exp_second(input logic [7:0] b, c, e1, e2);
        return 8'(|((b & e1 & gpsw_pkg::GPSW_BANK_B_MASK) | (c & e2)));
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One-cycle strobe, then settle past the answering edge
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge CLOCK);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge CLOCK);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        op(a, 8'h00, 1'b0);
        check(rdata, exp);
    endtask
    // Bounded wait on the interrupt level
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 8) begin
            @(posedge CLOCK);
            #1;
            n++;
        end
        check(8'(irq), 8'(exp));
        if (n == 8) stop_test();
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'hc0d2));
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        rd(gpsw_pkg::GPSW_IDX_CFG, 8'h00);
        rd(gpsw_pkg::GPSW_IDX_BANK_B, 8'h00);
        // Random pin levels and enables
        repeat (16) begin
            {ea, eb, ec} = 24'($urandom);
            pa <= 8'($urandom);
            pb <= 8'($urandom);
            pc <= 8'($urandom);
            ext <= 24'($urandom);
            op(gpsw_pkg::GPSW_IDX_IRQ_EN_A, ea, 1'b1);
            op(gpsw_pkg::GPSW_IDX_IRQ_EN_B, eb, 1'b1);
            op(gpsw_pkg::GPSW_IDX_IRQ_EN_C, ec, 1'b1);
            op(gpsw_pkg::GPSW_IDX_BANK_A, ~pa, 1'b1);
            rd(gpsw_pkg::GPSW_IDX_BANK_A, pa);
            rd(gpsw_pkg::GPSW_IDX_BANK_B, pb & 8'h1d);
            rd(gpsw_pkg::GPSW_IDX_BANK_C, pc);
            check(8'(irq1), 8'(|(pa & ea)));
            check(8'(irq2), exp_second(pb, pc, eb, ec));
        end
        // Runtime window, then config mode hides it
        cfg_mode <= 1'b0;
        rd(8'h01, pa);
        rd(8'h02, ext.wdog);
        rd(8'h03, pb & 8'h1d);
        rd(8'h04, pc);
        rd(8'h05, ext.spwr_en);
        rd(8'h06, ext.spwr_sts);
        cfg_mode <= 1'b1;
        rd(8'h01, 8'h00);
        op(gpsw_pkg::GPSW_IDX_CFG, 8'hff, 1'b1);
        rd(gpsw_pkg::GPSW_IDX_CFG, 8'h83);
        check(8'(pll), 8'h01);
        // Sleep write under both action selects
        for (int s = 0; s < 2; s++) begin
            t = 3'($urandom);
            op(gpsw_pkg::GPSW_IDX_CFG, 8'(s), 1'b1);
            rd(gpsw_pkg::GPSW_IDX_CFG, 8'(s));
            check(8'(pll), 8'h00);
            op(gpsw_pkg::GPSW_IDX_SLEEP, {4'h0, t, 1'b0}, 1'b1);
            check(8'({slp, system_mgmt_interrupt}), 8'h00);
            op(gpsw_pkg::GPSW_IDX_SLEEP, {4'h0, t, 1'b1}, 1'b1);
            check(8'({slp, system_mgmt_interrupt}), s ? 8'h01 : 8'h02);
            rd(gpsw_pkg::GPSW_IDX_STATUS, s ? 8'h09 : 8'h05);
            rd(gpsw_pkg::GPSW_IDX_STATUS, 8'h00);
            check(8'(slp_type), 8'(t));
        end
        // Wake sources under both wake selects
        for (int w = 0; w < 2; w++) begin
            op(gpsw_pkg::GPSW_IDX_CFG, 8'(w << 1), 1'b1);
            wake_ev <= 1'b1;
            @(posedge CLOCK);
            wake_ev <= 1'b0;
            repeat (3) @(posedge CLOCK);
            rd(gpsw_pkg::GPSW_IDX_STATUS, 8'(w << 1));
            pon_n <= 1'b0;
            repeat (3) @(posedge CLOCK);
            rd(gpsw_pkg::GPSW_IDX_STATUS, 8'h02);
            pon_n <= 1'b1;
        end
        // Interrupt raised, masked, unmasked and cleared
        op(gpsw_pkg::GPSW_IDX_MASK, 8'h02, 1'b1);
        pon_n <= 1'b0;
        wait_irq(1'b1);
        op(gpsw_pkg::GPSW_IDX_MASK, 8'h00, 1'b1);
        wait_irq(1'b0);
        op(gpsw_pkg::GPSW_IDX_MASK, 8'h02, 1'b1);
        wait_irq(1'b1);
        rd(gpsw_pkg::GPSW_IDX_STATUS, 8'h02);
        wait_irq(1'b0);
        // Clock enable low drops a config write
        ce <= 1'b0;
        op(gpsw_pkg::GPSW_IDX_CFG, 8'h80, 1'b1);
        ce <= 1'b1;
        rd(gpsw_pkg::GPSW_IDX_CFG, 8'h02);
        check(8'(pll), 8'h00);
        rd(8'h80, 8'h00);
        stop_test();
    end
endmodule
